// ### src/opcfg_regs.svh
// Register offsets, field positions and reset values of the amplifier configuration bank.
`ifndef OPCFG_REGS_SVH
`define OPCFG_REGS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OPCFG_BIAS_OFF 12'h030
`define OPCFG_CTRL_OFF 12'h054
`define OPCFG_TRIM_OFF 12'h058
`define OPCFG_MUX_OFF 12'h05C
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define OPCFG_HALVE_BIT 6
`define OPCFG_HALVE_RST 1'h1
`define OPCFG_LEVEL_HI 3
`define OPCFG_LEVEL_LO 0
`define OPCFG_LEVEL_RST 4'h7
`define OPCFG_SHORT_LO 22
`define OPCFG_FILT_LO 12
`define OPCFG_RAIL_LO 6
`define OPCFG_ON_LO 0
`define OPCFG_TRIM_HI 5
`define OPCFG_TRIM_LO 0
`define OPCFG_TAP_HI 30
`define OPCFG_TAP_LO 28
`define OPCFG_TAP_RST 3'h0
`define OPCFG_CHAIN_BIT 26
`define OPCFG_ROUTE_HI 23
`define OPCFG_ROUTE_LO 22
`define OPCFG_ROUTE_RST 2'h1
`endif

// ### src/opcfg_pkg.sv
// Types shared by the amplifier configuration bank.
package opcfg_pkg;
  // Output route codes of amplifier 0.
  typedef enum logic [1:0] {
    OPCFG_ROUTE_OFF = 2'h0,
    OPCFG_ROUTE_MAIN = 2'h1,
    OPCFG_ROUTE_SECONDARY = 2'h2,
    OPCFG_ROUTE_BOTH = 2'h3
  } opcfg_route_e;
  // Per-amplifier filter bypass codes.
  typedef enum logic [1:0] {
    OPCFG_FILT_NONE = 2'h0,
    OPCFG_POS_PATH_FILTER_OFF = 2'h1,
    OPCFG_NEG_PATH_FILTER_OFF = 2'h2,
    OPCFG_FILT_RSVD = 2'h3
  } opcfg_filt_e;
endpackage : opcfg_pkg

// ### src/opcfg_top.sv
// APB register bank for three amplifiers: bias, control, offset trim and amplifier 0 mux.
//
// Function
// - Bias halve bit 6, resets one
// - Bias level bits 3:0, resets 0x7
// - Filter bypass fields 17:12, codes 1/2
// - Rail input off bits 8:6
// - Amplifier enable bits 2:0
// - Six-bit sign-magnitude trim at 0x058
// - Trim resets to zero, then loads per-part calibration
// - Ladder tap select bits 30:28
// - Chain bit 26 feeds amplifier 1
// - Output route 23:22, resets to main
// - Route code 3 drives both outputs
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "opcfg_regs.svh"
module opcfg_top #(
  parameter int NUM_AMPS = 3
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Production calibration value of the trim, static from fuses.
  input wire logic [5:0] trim_calib,
  // Bias controls.
  output logic bias_halve,
  output logic [3:0] bias_level,
  // Per-amplifier controls, index is the amplifier number.
  output logic [NUM_AMPS-1:0] amp_input_short,
  output logic [NUM_AMPS-1:0] pos_path_filter_off,
  output logic [NUM_AMPS-1:0] neg_path_filter_off,
  output logic [NUM_AMPS-1:0] amp_rail_input_off,
  output logic [NUM_AMPS-1:0] amp_on,
  // Amplifier 2 trim and amplifier 0 mux.
  output logic [5:0] amp2_trim,
  output logic [2:0] ladder_tap_sel,
  output logic chain_to_next_amp,
  output logic route_main,
  output logic route_secondary
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic bias_halve_q;
  logic [3:0] bias_level_q;
  logic [NUM_AMPS-1:0] short_q;
  logic [2*NUM_AMPS-1:0] filt_q;
  logic [NUM_AMPS-1:0] rail_q;
  logic [NUM_AMPS-1:0] on_q;
  logic [5:0] trim_q;
  logic trim_loaded_q;
  logic [2:0] tap_q;
  logic chain_q;
  opcfg_pkg::opcfg_route_e route_q;
  logic [31:0] ctrl_word;
  logic [31:0] rd_d;
  logic wr_en;
  logic rd_en;
  logic [31:0] wmask;
  logic [31:0] wval;

  // The access phase completes in one cycle, so pready is held high from the first clock after reset.
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wval = pwdata & wmask;

  // Packs the control register image for readback.
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`OPCFG_SHORT_LO +: NUM_AMPS] = short_q;
    ctrl_word[`OPCFG_FILT_LO +: 2*NUM_AMPS] = filt_q;
    ctrl_word[`OPCFG_RAIL_LO +: NUM_AMPS] = rail_q;
    ctrl_word[`OPCFG_ON_LO +: NUM_AMPS] = on_q;
  end

  // ****************************************************************
  // Bias register
  // ****************************************************************
  // Bias fields update on a completed write; byte 0 holds both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_halve_q <= `OPCFG_HALVE_RST;
      bias_level_q <= `OPCFG_LEVEL_RST;
    end else if (wr_en && paddr == `OPCFG_BIAS_OFF && pstrb[0]) begin
      bias_halve_q <= pwdata[`OPCFG_HALVE_BIT];
      bias_level_q <= pwdata[`OPCFG_LEVEL_HI:`OPCFG_LEVEL_LO];
    end
  end

  // ****************************************************************
  // Amplifier control register
  // ****************************************************************
  // Control fields take masked write data; unstrobed bytes keep old values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q <= '0;
      filt_q <= '0;
      rail_q <= '0;
      on_q <= '0;
    end else if (wr_en && paddr == `OPCFG_CTRL_OFF) begin
      short_q <= (wval[`OPCFG_SHORT_LO +: NUM_AMPS] & wmask[`OPCFG_SHORT_LO +: NUM_AMPS]) |
                 (short_q & ~wmask[`OPCFG_SHORT_LO +: NUM_AMPS]);
      filt_q <= (wval[`OPCFG_FILT_LO +: 2*NUM_AMPS]) |
                (filt_q & ~wmask[`OPCFG_FILT_LO +: 2*NUM_AMPS]);
      rail_q <= (wval[`OPCFG_RAIL_LO +: NUM_AMPS]) | (rail_q & ~wmask[`OPCFG_RAIL_LO +: NUM_AMPS]);
      on_q <= (wval[`OPCFG_ON_LO +: NUM_AMPS]) | (on_q & ~wmask[`OPCFG_ON_LO +: NUM_AMPS]);
    end
  end

  // ****************************************************************
  // Offset trim register
  // ****************************************************************
  // Reset clears the trim; the first clock after release loads the calibration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= 6'h00;
      trim_loaded_q <= 1'b0;
    end else if (!trim_loaded_q) begin
      trim_q <= trim_calib;
      trim_loaded_q <= 1'b1;
    end else if (wr_en && paddr == `OPCFG_TRIM_OFF && pstrb[0]) begin
      trim_q <= pwdata[`OPCFG_TRIM_HI:`OPCFG_TRIM_LO];
    end
  end

  // ****************************************************************
  // Amplifier 0 mux register
  // ****************************************************************
  // Tap and chain sit in byte 3, the route in byte 2.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_q <= `OPCFG_TAP_RST;
      chain_q <= 1'b0;
      route_q <= opcfg_pkg::opcfg_route_e'(`OPCFG_ROUTE_RST);
    end else if (wr_en && paddr == `OPCFG_MUX_OFF) begin
      if (pstrb[3]) begin
        tap_q <= pwdata[`OPCFG_TAP_HI:`OPCFG_TAP_LO];
        chain_q <= pwdata[`OPCFG_CHAIN_BIT];
      end
      if (pstrb[2]) begin
        route_q <= opcfg_pkg::opcfg_route_e'(pwdata[`OPCFG_ROUTE_HI:`OPCFG_ROUTE_LO]);
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Selects the readback word; reserved bits and unmapped offsets read zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `OPCFG_BIAS_OFF: begin
        rd_d[`OPCFG_HALVE_BIT] = bias_halve_q;
        rd_d[`OPCFG_LEVEL_HI:`OPCFG_LEVEL_LO] = bias_level_q;
      end
      `OPCFG_CTRL_OFF: rd_d = ctrl_word;
      `OPCFG_TRIM_OFF: rd_d[`OPCFG_TRIM_HI:`OPCFG_TRIM_LO] = trim_q;
      `OPCFG_MUX_OFF: begin
        rd_d[`OPCFG_TAP_HI:`OPCFG_TAP_LO] = tap_q;
        rd_d[`OPCFG_CHAIN_BIT] = chain_q;
        rd_d[`OPCFG_ROUTE_HI:`OPCFG_ROUTE_LO] = route_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  // Registers every control line so outputs come straight from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_halve <= `OPCFG_HALVE_RST;
      bias_level <= `OPCFG_LEVEL_RST;
      amp_input_short <= '0;
      pos_path_filter_off <= '0;
      neg_path_filter_off <= '0;
      amp_rail_input_off <= '0;
      amp_on <= '0;
      amp2_trim <= 6'h00;
      ladder_tap_sel <= `OPCFG_TAP_RST;
      chain_to_next_amp <= 1'b0;
      route_main <= 1'b1;
      route_secondary <= 1'b0;
    end else begin
      bias_halve <= bias_halve_q;
      bias_level <= bias_level_q;
      amp_input_short <= short_q;
      for (int i = 0; i < NUM_AMPS; i++) begin
        pos_path_filter_off[i] <= filt_q[2*i] ;
        neg_path_filter_off[i] <= filt_q[2*i+1];
      end
      amp_rail_input_off <= rail_q;
      amp_on <= on_q;
      amp2_trim <= trim_q;
      ladder_tap_sel <= tap_q;
      chain_to_next_amp <= chain_q;
      route_main <= route_q[0];
      route_secondary <= route_q[1];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_HALVE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_BIAS_OFF && pstrb[0]) |=> ##1 (bias_halve == $past(pwdata[6], 2)))
    else $error("Halve output does not follow the write.");
  AST_LEVEL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_BIAS_OFF && pstrb[0]) |=> ##1 (bias_level == $past(pwdata[3:0], 2)))
    else $error("Bias level output does not follow the write.");
  AST_SHORT_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_CTRL_OFF && pstrb[2] && pstrb[3]) |=> ##1
      (amp_input_short == $past(pwdata[24:22], 2)))
    else $error("Input short output does not follow the write.");
  AST_FILT_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_CTRL_OFF && pstrb[1] && pstrb[2]) |=> ##1
      (pos_path_filter_off[2] == $past(pwdata[16], 2) && neg_path_filter_off[0] == $past(pwdata[13], 2)))
    else $error("Filter bypass decode is wrong.");
  AST_RAIL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_CTRL_OFF && pstrb[0] && pstrb[1]) |=> ##1
      (amp_rail_input_off == $past(pwdata[8:6], 2)))
    else $error("Rail input output does not follow the write.");
  AST_ON_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_CTRL_OFF && pstrb[0]) |=> ##1 (amp_on == $past(pwdata[2:0], 2)))
    else $error("Enable output does not follow the write.");
  AST_TRIM_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(trim_loaded_q) |-> ##1 (amp2_trim == $past(trim_calib, 2)))
    else $error("Trim did not load the calibration value.");
  AST_TAP_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OPCFG_MUX_OFF && pstrb[3]) |=> ##1
      (ladder_tap_sel == $past(pwdata[30:28], 2) && chain_to_next_amp == $past(pwdata[26], 2)))
    else $error("Tap or chain output does not follow the write.");
  AST_ROUTE_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    (route_q == opcfg_pkg::OPCFG_ROUTE_BOTH) |=> (route_main && route_secondary))
    else $error("Route code 3 does not drive both outputs.");
  AST_READ_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `OPCFG_TRIM_OFF) |=> (prdata[31:6] == 26'h0 && prdata[5:0] == $past(trim_q)))
    else $error("Trim readback is wrong.");

endmodule : opcfg_top

// ### verif/tb_opcfg_top.sv
// Self-checking testbench of the amplifier configuration register bank.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end end
module tb_opcfg_top;
  // ****************************************************************
  // Signals and expected register images
  // ****************************************************************
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] r;} opcfg_row_s;
  localparam logic [31:0] MSK [4] = '{32'h0000_004F, 32'h01C3_F1C7, 32'h0000_003F, 32'h74C0_0000};
  localparam int NROW = 9;
  // Reserved bits zero, except rows that probe refusal.
  localparam opcfg_row_s ROWS [NROW] = '{
    '{12'h030, 32'hFFFF_FFFF, 32'h0000_004F}, '{12'h030, 32'h0000_0005, 32'h0000_0005},
    '{12'h054, 32'hFFFF_FFFF, 32'h01C3_F1C7}, '{12'h054, 32'h0040_9142, 32'h0040_9142},
    '{12'h054, 32'h0181_2084, 32'h0181_2084}, '{12'h058, 32'hFFFF_FFFF, 32'h0000_003F},
    '{12'h058, 32'h0000_0025, 32'h0000_0025}, '{12'h040, 32'hFFFF_FFFF, 32'h0000_0000},
    '{12'h000, 32'h0000_0000, 32'h0000_0000}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, bias_level;
  logic [5:0] trim_calib, amp2_trim;
  logic bias_halve, chain_to_next_amp, route_main, route_secondary;
  logic [2:0] amp_input_short, pos_path_filter_off, neg_path_filter_off, amp_rail_input_off, amp_on, ladder_tap_sel;
  logic [31:0] img [4];
  int failures = 0;
  int checks = 0;
  wire [31:0] obs = {bias_halve, bias_level, amp_input_short, pos_path_filter_off, neg_path_filter_off,
    amp_rail_input_off, amp_on, amp2_trim, ladder_tap_sel, chain_to_next_amp, route_main, route_secondary};

  // Device under test.
  opcfg_top #(.NUM_AMPS(3)) u_opcfg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trim_calib(trim_calib), .bias_halve(bias_halve), .bias_level(bias_level),
    .amp_input_short(amp_input_short), .pos_path_filter_off(pos_path_filter_off),
    .neg_path_filter_off(neg_path_filter_off), .amp_rail_input_off(amp_rail_input_off), .amp_on(amp_on),
    .amp2_trim(amp2_trim), .ladder_tap_sel(ladder_tap_sel), .chain_to_next_amp(chain_to_next_amp),
    .route_main(route_main), .route_secondary(route_secondary));

  // ****************************************************************
  // Model helpers and bus tasks
  // ****************************************************************
  // Maps a byte address to a register index, or -1 when unmapped.
  function automatic int idx(input logic [11:0] a);
    case (a)
      12'h030: idx = 0;
      12'h054: idx = 1;
      12'h058: idx = 2;
      12'h05C: idx = 3;
      default: idx = -1;
    endcase
  endfunction : idx

  // Builds the expected control outputs from the register images.
  function automatic logic [31:0] exp_obs();
    logic [31:0] c;
    c = img[1];
    exp_obs = {img[0][6], img[0][3:0], c[24:22], c[16], c[14], c[12], c[17], c[15], c[13], c[8:6], c[2:0],
      img[2][5:0], img[3][30:28], img[3][26], img[3][22], img[3][23]};
  endfunction : exp_obs

  // Loads the images with the values expected after reset.
  task automatic set_reset_img();
    img[0] = 32'h0000_0047;
    img[1] = 32'h0000_0000;
    img[2] = {26'h0, trim_calib};
    img[3] = 32'h0040_0000;
  endtask : set_reset_img

  // One APB transfer; holds the request until pready is seen, then updates the model.
  // Assumes no count of wait states: only the watchdog ends a wait that never ends.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = idx(a);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (wr && k >= 0 && s[b]) img[k][8*b +: 8] = d[8*b +: 8] & MSK[k][8*b +: 8];
    end
  endtask : apb

  // Reads a register, compares it with the given value and all control outputs with the model.
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK(rd, exp)
    `CHK(obs, exp_obs())
    `CHK(pslverr, 1'b0)
  endtask : chk_reg

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    trim_calib = 6'h2B;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    set_reset_img();
    chk_reg(12'h030, 32'h0000_0047);
    chk_reg(12'h054, 32'h0000_0000);
    chk_reg(12'h058, 32'h0000_002B);
    chk_reg(12'h05C, 32'h0040_0000);
    for (int i = 0; i < NROW; i++) begin
      apb(1'b1, ROWS[i].a, ROWS[i].d, 4'hF);
      chk_reg(ROWS[i].a, ROWS[i].r);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h05C, {1'b0, i[2:0], 1'b0, i[0], 2'h0, i[1:0], 22'h0}, 4'hF);
      chk_reg(12'h05C, {1'b0, i[2:0], 1'b0, i[0], 2'h0, i[1:0], 22'h0});
    end
    apb(1'b1, 12'h054, 32'hFFFF_FFFF, 4'h1);
    chk_reg(12'h054, 32'h0181_20C7);
    apb(1'b1, 12'h05C, 32'h0000_0000, 4'h4);
    chk_reg(12'h05C, 32'h7400_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    trim_calib <= 6'h1A;
    repeat (2) @(negedge pclk);
    set_reset_img();
    img[2] = 32'h0000_0000;
    `CHK(obs, exp_obs())
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    set_reset_img();
    chk_reg(12'h058, 32'h0000_001A);
    finish_test();
  end
endmodule : tb_opcfg_top
